// ---- tdp_driver_test_ctl.sv ----
// What this block does
// R1: Power-down bit set (default) keeps driver off with outputs high impedance.
// R2: Duty-distortion boost bit raises compensation; resets to zero.
// R3: Square test bit drives waveshaper sources fully on or off.
// R4: Software writes zero into reserved bits 12 and 10.
// R5: Edge rise and fall bits load from straps, then software read/write.
// R6: Driver test enable selects speed-dependent driver test mode.
// R7: 100 Mb/s pattern enable transmits the selected 100 Mb/s pattern.
// R8: 100 Mb/s select: zeros, ones, two-two, fourteen-six.
// R9: 10 Mb/s pattern enable transmits the selected 10 Mb/s sequence.
// R10: 10 Mb/s select: data+end A, data+end B, link pulses, tone.
// R11: Gap between 10 Mb/s sequences is 15 us when set, else 10 us.
// R12: With no pattern enabled, select and gap are ignored; normal traffic passes.
`timescale 1ns/1ns
`include "tdp_map.svh"

module tdp_driver_test_ctl #(
    parameter logic [7:0] DATA_LEN = 8'h40,
    parameter logic [7:0] EOP_LEN  = 8'h02,
    parameter logic [7:0] NLP_LEN  = 8'h01
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    input  wire tdp_pkg::tdp_apb_req_t apb_req,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                strap_rise,
    input  wire logic                strap_fall,
    input  wire logic                speed_100,
    input  wire logic                normal_tx_bit,
    output tdp_pkg::tdp_drv_t        drv,
    output logic                     line_bit,
    output logic                     line_oe
);
    import tdp_pkg::*;

    tdp_main_st_t st_r;
    tdp_main_st_t st_nxt;
    logic         hit;
    logic         wr_fire;
    logic         run100;
    logic         run10;
    logic         p100_bit;
    logic [7:0]   gap_len;

    // ------------------------------------------------------------------------
    // APB slave: one mapped word, zero wait on writes, one capture on reads
    // ------------------------------------------------------------------------
    assign hit     = (apb_req.paddr == `TDP_CTL_OFFSET);
    assign pready  = clk_en && (apb_req.pwrite || st_r.rd_ok);
    assign pslverr = apb_req.psel && apb_req.penable && pready && !hit;
    assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && hit && clk_en;
    assign prdata  = st_r.prdata;

    // Both enables may be set; only the one matching the live speed runs.
    assign run100  = st_r.ctl.pattern_en_100m && speed_100; // R7
    assign run10   = st_r.ctl.pattern_en_10m && !speed_100; // R9
    assign gap_len = st_r.ctl.pattern_gap_sel ? 8'(`TDP_GAP_LONG_CYC)
                                              : 8'(`TDP_GAP_SHORT_CYC); // R11

    tdp_pat100 u_pat100 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .run      (run100),
        .sel      (st_r.ctl.pattern_select),
        .bit_out  (p100_bit)
    );

    // ------------------------------------------------------------------------
    // Register, strap capture and 10 Mb/s sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Straps are sampled one cycle after reset, never under reset itself.
        if (st_r.strap_pend) begin
            st_nxt.ctl.edge_rise_ctl = strap_rise; // R5
            st_nxt.ctl.edge_fall_ctl = strap_fall; // R5
            st_nxt.strap_pend        = 1'b0;
        end
        // Reserved bits are stored as written; software is expected to write zero.
        if (wr_fire) begin
            st_nxt.ctl = tdp_ctl_t'(apb_req.pwdata[15:0]); // R4
        end
        if (!apb_req.psel || (apb_req.penable && pready)) begin
            st_nxt.rd_ok = 1'b0;
        end else if (!apb_req.pwrite) begin
            st_nxt.rd_ok  = 1'b1;
            st_nxt.prdata = hit ? {16'h0000, st_r.ctl} : 32'h0000_0000;
        end

        // The data scrambler starts from zero, so data sequences carry only zeros.
        // Framing, end-of-packet level and gap timing are what the line then shows.
        st_nxt.lfsr = {st_r.lfsr[6:0], st_r.lfsr[7] ^ st_r.lfsr[5] ^ st_r.lfsr[4] ^ st_r.lfsr[3]};
        st_nxt.cnt  = (st_r.cnt == 8'h00) ? 8'h00 : st_r.cnt - 8'h01;
        if (!run10) begin
            st_nxt.seq    = seq_idle;
            st_nxt.tx_bit = 1'b0;
        end else begin
            case (st_r.seq) // R10
                seq_idle: begin
                    st_nxt.tx_bit = 1'b0;
                    if (st_r.ctl.pattern_select == 2'h2) begin
                        st_nxt.seq = seq_nlp;
                        st_nxt.cnt = NLP_LEN - 8'h01;
                    end else if (st_r.ctl.pattern_select == 2'h3) begin
                        st_nxt.seq = seq_tone;
                    end else begin
                        st_nxt.seq = seq_data;
                        st_nxt.cnt = DATA_LEN - 8'h01;
                    end
                end
                seq_data: begin
                    st_nxt.tx_bit = st_r.lfsr[0];
                    if (st_r.cnt == 8'h00) begin
                        st_nxt.seq = seq_eop;
                        st_nxt.cnt = EOP_LEN - 8'h01;
                    end
                end
                seq_eop: begin
                    // Variant a ends the packet high, variant b ends it low.
                    st_nxt.tx_bit = (st_r.ctl.pattern_select == 2'h0);
                    if (st_r.cnt == 8'h00) begin
                        st_nxt.seq = seq_gap;
                        st_nxt.cnt = gap_len - 8'h01; // R11
                    end
                end
                seq_nlp: begin
                    st_nxt.tx_bit = 1'b1;
                    if (st_r.cnt == 8'h00) begin
                        st_nxt.seq = seq_gap;
                        st_nxt.cnt = gap_len - 8'h01; // R11
                    end
                end
                seq_gap: begin
                    st_nxt.tx_bit = 1'b0;
                    if (st_r.cnt == 8'h00) begin
                        st_nxt.seq = seq_idle;
                    end
                end
                seq_tone: begin
                    st_nxt.tx_bit = !st_r.tx_bit;
                    if (st_r.ctl.pattern_select != 2'h3) begin
                        st_nxt.seq = seq_idle;
                    end
                end
                default: begin
                    st_nxt.seq = seq_idle;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r            <= '0;
            st_r.ctl        <= tdp_ctl_t'(`TDP_CTL_RESET); // R1 R2
            st_r.strap_pend <= 1'b1;
            st_r.seq        <= seq_idle;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Driver controls and line output
    // ------------------------------------------------------------------------
    assign drv.powerdown   = st_r.ctl.driver_powerdown_ctl;   // R1
    assign drv.dcd_boost   = st_r.ctl.duty_distortion_boost;  // R2
    assign drv.square_test = st_r.ctl.waveshaper_square_test; // R3
    assign drv.edge_rise   = st_r.ctl.edge_rise_ctl;          // R5
    assign drv.edge_fall   = st_r.ctl.edge_fall_ctl;          // R5
    assign drv.test_enable = st_r.ctl.driver_test_enable;     // R6

    // Powered down means the pair is released, whatever the source would send.
    assign line_oe = !st_r.ctl.driver_powerdown_ctl; // R1

    logic line_bit_r;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_bit_r <= 1'b0;
        end else if (clk_en) begin
            if (!line_oe) begin
                line_bit_r <= 1'b0;
            end else if (run100) begin
                line_bit_r <= p100_bit; // R7
            end else if (run10) begin
                line_bit_r <= st_r.tx_bit; // R9
            end else begin
                line_bit_r <= normal_tx_bit; // R12
            end
        end
    end
    assign line_bit = line_bit_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_pd_hiz;
        @(posedge core_clk) disable iff (!rstn)
        (wr_fire && apb_req.pwdata[`TDP_BIT_PD]) |=> !line_oe ##1 (!line_bit || !$past(clk_en));
    endproperty
    a_pd_hiz: assert property (p_pd_hiz) else $error("power-down not honoured"); // R1

    property p_dcd;
        @(posedge core_clk) disable iff (!rstn)
        wr_fire |=> drv.dcd_boost == $past(apb_req.pwdata[`TDP_BIT_DCD]);
    endproperty
    a_dcd: assert property (p_dcd) else $error("boost control not written"); // R2

    property p_square;
        @(posedge core_clk) disable iff (!rstn)
        wr_fire |=> drv.square_test == $past(apb_req.pwdata[`TDP_BIT_SQ]);
    endproperty
    a_square: assert property (p_square) else $error("square test not written"); // R3

    property p_strap;
        @(posedge core_clk) disable iff (!rstn)
        (rstn && st_r.strap_pend && clk_en && !wr_fire) |=>
            (drv.edge_rise == $past(strap_rise)) && (drv.edge_fall == $past(strap_fall));
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured"); // R5

    property p_test_en;
        @(posedge core_clk) disable iff (!rstn)
        wr_fire |=> drv.test_enable == $past(apb_req.pwdata[`TDP_BIT_TEST]);
    endproperty
    a_test_en: assert property (p_test_en) else $error("test enable not written"); // R6

    property p_run100;
        @(posedge core_clk) disable iff (!rstn)
        (wr_fire && apb_req.pwdata[`TDP_BIT_EN100]) |=> run100 == speed_100;
    endproperty
    a_run100: assert property (p_run100) else $error("100M pattern not started"); // R7

    property p_run10;
        @(posedge core_clk) disable iff (!rstn)
        (run10 && clk_en && st_r.seq == seq_idle && st_r.ctl.pattern_select == 2'h2)
            |=> st_r.seq == seq_nlp;
    endproperty
    a_run10: assert property (p_run10) else $error("link pulse not started"); // R9

    property p_tone;
        @(posedge core_clk) disable iff (!rstn)
        (run10 && clk_en && st_r.seq == seq_tone && st_r.ctl.pattern_select == 2'h3)
            |=> st_r.tx_bit != $past(st_r.tx_bit);
    endproperty
    a_tone: assert property (p_tone) else $error("tone does not toggle"); // R10

    property p_gap;
        @(posedge core_clk) disable iff (!rstn)
        (clk_en && run10 && st_r.seq == seq_nlp && st_r.cnt == 8'h00 && !wr_fire) |=>
            st_r.cnt == ($past(st_r.ctl.pattern_gap_sel) ? 8'(`TDP_GAP_LONG_CYC - 1)
                                                        : 8'(`TDP_GAP_SHORT_CYC - 1));
    endproperty
    a_gap: assert property (p_gap) else $error("gap length wrong"); // R11

    property p_normal;
        @(posedge core_clk) disable iff (!rstn)
        (clk_en && line_oe && !run100 && !run10) |=> line_bit == $past(normal_tx_bit);
    endproperty
    a_normal: assert property (p_normal) else $error("normal traffic blocked"); // R12

    property p_p100_line;
        @(posedge core_clk) disable iff (!rstn)
        (clk_en && line_oe && run100) |=> line_bit == $past(p100_bit);
    endproperty
    a_p100_line: assert property (p_p100_line) else $error("100M pattern not on line"); // R7

    property p_eop_level;
        @(posedge core_clk) disable iff (!rstn)
        (clk_en && run10 && st_r.seq == seq_eop)
            |=> st_r.tx_bit == ($past(st_r.ctl.pattern_select) == 2'h0);
    endproperty
    a_eop_level: assert property (p_eop_level) else $error("end-of-packet level wrong"); // R10

    property p_rd_capture;
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit && clk_en)
            |=> prdata == {16'h0000, $past(st_r.ctl)};
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("read data not captured"); // R5

    // Writes outside the map must leave the control word alone.
    property p_unmapped_wr;
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && apb_req.penable && apb_req.pwrite && !hit
            && clk_en && !st_r.strap_pend) |=> $stable(st_r.ctl);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    // A low enable must hold every register, the line output included.
    property p_freeze;
        @(posedge core_clk) disable iff (!rstn)
        !clk_en |=> $stable(st_r) && $stable(line_bit);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    c_write: cover property (@(posedge core_clk) disable iff (!rstn) wr_fire);
    c_tone: cover property (@(posedge core_clk) disable iff (!rstn) st_r.seq == seq_tone);
    c_nlp_gap: cover property (@(posedge core_clk) disable iff (!rstn)
        st_r.seq == seq_nlp ##1 st_r.seq == seq_gap);
    c_eop: cover property (@(posedge core_clk) disable iff (!rstn) st_r.seq == seq_eop);
    c_p100: cover property (@(posedge core_clk) disable iff (!rstn) run100 && p100_bit);

endmodule

// ---- tdp_map.svh ----
`ifndef TDP_MAP_SVH
`define TDP_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TDP_CTL_OFFSET   8'h00
`define TDP_CTL_RESET    16'h8000

// ----------------------------------------------------------------------------
// Field positions of the driver test control register
// ----------------------------------------------------------------------------
`define TDP_BIT_PD       15
`define TDP_BIT_DCD      14
`define TDP_BIT_SQ       13
`define TDP_BIT_RISE     11
`define TDP_BIT_FALL     9
`define TDP_BIT_TEST     8
`define TDP_BIT_EN10     4
`define TDP_BIT_EN100    3
`define TDP_BIT_GAP      2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TDP_CLK_MHZ      10
`define TDP_GAP_SHORT_US 10
`define TDP_GAP_LONG_US  15
`define TDP_GAP_SHORT_CYC (`TDP_GAP_SHORT_US * `TDP_CLK_MHZ)
`define TDP_GAP_LONG_CYC  (`TDP_GAP_LONG_US * `TDP_CLK_MHZ)
`define TDP_P100_HALF2   4
`define TDP_P100_ONES14  14
`define TDP_P100_LEN20   20

`endif

// ---- tdp_pkg.sv ----
package tdp_pkg;

    typedef struct packed {
        logic       driver_powerdown_ctl;
        logic       duty_distortion_boost;
        logic       waveshaper_square_test;
        logic       rsv12;
        logic       edge_rise_ctl;
        logic       rsv10;
        logic       edge_fall_ctl;
        logic       driver_test_enable;
        logic [2:0] rsv7;
        logic       pattern_en_10m;
        logic       pattern_en_100m;
        logic       pattern_gap_sel;
        logic [1:0] pattern_select;
    } tdp_ctl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tdp_apb_req_t;

    typedef struct packed {
        logic powerdown;
        logic dcd_boost;
        logic square_test;
        logic edge_rise;
        logic edge_fall;
        logic test_enable;
    } tdp_drv_t;

    typedef enum logic [2:0] {
        seq_idle = 3'b000,
        seq_data = 3'b001,
        seq_eop  = 3'b010,
        seq_nlp  = 3'b011,
        seq_gap  = 3'b100,
        seq_tone = 3'b101
    } tdp_seq_t;

    typedef struct packed {
        tdp_ctl_t    ctl;
        logic        strap_pend;
        logic        rd_ok;
        logic [31:0] prdata;
        tdp_seq_t    seq;
        logic [7:0]  cnt;
        logic [7:0]  lfsr;
        logic        tx_bit;
    } tdp_main_st_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic       bit_out;
    } tdp_p100_st_t;

endpackage

// ---- tdp_pat100.sv ----
`timescale 1ns/1ns
`include "tdp_map.svh"

module tdp_pat100 (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            bit_out
);
    import tdp_pkg::*;

    tdp_p100_st_t st_r;
    tdp_p100_st_t st_nxt;
    logic [4:0]   len;

    // ------------------------------------------------------------------------
    // Fixed 100 Mb/s compliance patterns
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        len    = (sel == 2'h2) ? 5'(`TDP_P100_HALF2) : 5'(`TDP_P100_LEN20);
        if (!run) begin
            st_nxt.cnt     = 5'h00;
            st_nxt.bit_out = 1'b0;
        end else begin
            st_nxt.cnt = (st_r.cnt >= len - 5'h01) ? 5'h00 : st_r.cnt + 5'h01;
            case (sel) // R8
                2'h0: st_nxt.bit_out = 1'b0;
                2'h1: st_nxt.bit_out = 1'b1;
                2'h2: st_nxt.bit_out = (st_r.cnt < 5'(`TDP_P100_HALF2 / 2));
                default: st_nxt.bit_out = (st_r.cnt < 5'(`TDP_P100_ONES14));
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign bit_out = st_r.bit_out;

    property p_p100_ones;
        @(posedge core_clk) disable iff (!rstn)
        (run && clk_en && sel == 2'h1) |=> bit_out;
    endproperty
    a_p100_ones: assert property (p_p100_ones) else $error("ones pattern broken"); // R8

    property p_p100_quiet;
        @(posedge core_clk) disable iff (!rstn)
        (run && clk_en && sel == 2'h0) |=> !bit_out;
    endproperty
    a_p100_quiet: assert property (p_p100_quiet) else $error("quiet pattern broken"); // R8

endmodule

// ---- tdp_line_model.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Twisted-pair line as seen through the transformer
// ----------------------------------------------------------------------------
module tdp_line_model (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        line_bit,
    input  wire logic        line_oe,
    output logic             rx_level,
    output logic [15:0]      hi_run,
    output logic [15:0]      period
);
    logic        last_r;
    logic [15:0] run_r;
    logic [15:0] since_r;

    // A released line has no pull, so it wanders instead of holding the last bit.
    assign rx_level = line_oe ? line_bit : ~last_r;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            last_r  <= 1'b0;
            run_r   <= 16'h0000;
            since_r <= 16'h0000;
            hi_run  <= 16'h0000;
            period  <= 16'h0000;
        end else begin
            last_r <= rx_level;
            if (rx_level) begin
                run_r <= run_r + 16'h0001;
            end else begin
                run_r <= 16'h0000;
            end
            if (!rx_level && last_r) begin
                hi_run <= run_r;
            end
            if (rx_level && !last_r) begin
                period  <= since_r + 16'h0001;
                since_r <= 16'h0000;
            end else begin
                since_r <= since_r + 16'h0001;
            end
        end
    end
endmodule

// ---- tdp_driver_test_ctl_tb.sv ----
`timescale 1ns/1ns

module tdp_driver_test_ctl_tb;
    import tdp_pkg::*;

    localparam int TIMEOUT = 20000;

    logic         core_clk      = 1'b0;
    logic         rstn          = 1'b0;
    logic         clk_en        = 1'b1;
    tdp_apb_req_t apb_req       = '0;
    logic         strap_rise    = 1'b1;
    logic         strap_fall    = 1'b0;
    logic         speed_100     = 1'b1;
    logic         normal_tx_bit = 1'b0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    tdp_drv_t     drv;
    logic         line_bit;
    logic         line_oe;
    logic         rx_level;
    logic [15:0]  hi_run;
    logic [15:0]  period;
    logic [15:0]  p0;
    logic [31:0]  cnt;
    int           num_errors    = 0;
    int           check_count   = 0;
    int           cycles        = 0;
    logic [31:0]  exp100 [4]    = '{32'h0000_0000, 32'h0000_0014, 32'h0000_000A, 32'h0000_000E};

    always #50 core_clk = ~core_clk;

    tdp_driver_test_ctl #(.DATA_LEN(8'h04)) u_dut (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .clk_en        (clk_en),
        .apb_req       (apb_req),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .strap_rise    (strap_rise),
        .strap_fall    (strap_fall),
        .speed_100     (speed_100),
        .normal_tx_bit (normal_tx_bit),
        .drv           (drv),
        .line_bit      (line_bit),
        .line_oe       (line_oe)
    );

    tdp_line_model u_line (
        .core_clk (core_clk),
        .rstn     (rstn),
        .line_bit (line_bit),
        .line_oe  (line_oe),
        .rx_level (rx_level),
        .hi_run   (hi_run),
        .period   (period)
    );

    // ------------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request stands until the rising edge at which pready is seen high.
    // Only the bench timeout ends a wait that never gets its answer.
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b1, adr, d, q, e);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, adr, 32'h0000_0000, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    task automatic ones(input int n, output logic [31:0] c);
        c = 32'h0000_0000;
        repeat (n) begin
            @(negedge core_clk);
            c = c + {31'h0, rx_level};
        end
    endtask

    // ------------------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            num_errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(8'h00, 32'h0000_8800, 1'b0);
        chk({31'h0, line_oe}, 32'h0000_0000);
        $display("test reset done");
        wr(8'h00, 32'h0000_6B00, 1'b0);
        rdc(8'h00, 32'h0000_6B00, 1'b0);
        chk({26'h0, drv}, 32'h0000_001F);
        chk({31'h0, line_oe}, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000, 1'b1);
        rdc(8'h04, 32'h0000_0000, 1'b1);
        rdc(8'h00, 32'h0000_6B00, 1'b0);
        $display("test fields done");
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'h0000_0008 | s, 1'b0);
            repeat (30) @(posedge core_clk);
            ones(20, cnt);
            chk(cnt, exp100[s]);
        end
        repeat (40) @(posedge core_clk);
        chk({16'h0, hi_run}, 32'h0000_000E);
        $display("test pattern100 done");
        speed_100 <= 1'b0;
        wr(8'h00, 32'h0000_0013, 1'b0);
        repeat (10) @(posedge core_clk);
        ones(20, cnt);
        chk(cnt, 32'h0000_000A);
        chk({16'h0, hi_run}, 32'h0000_0001);
        wr(8'h00, 32'h0000_0012, 1'b0);
        repeat (400) @(posedge core_clk);
        p0 = period;
        chk({16'h0, hi_run}, 32'h0000_0001);
        wr(8'h00, 32'h0000_0016, 1'b0);
        repeat (400) @(posedge core_clk);
        chk({16'h0, period - p0}, 32'h0000_0032);
        wr(8'h00, 32'h0000_0010, 1'b0);
        repeat (400) @(posedge core_clk);
        chk({16'h0, hi_run}, 32'h0000_0002);
        wr(8'h00, 32'h0000_0011, 1'b0);
        repeat (200) @(posedge core_clk);
        ones(200, cnt);
        chk(cnt, 32'h0000_0000);
        $display("test pattern10 done");
        wr(8'h00, 32'h0000_0007, 1'b0);
        normal_tx_bit <= 1'b1;
        repeat (3) @(posedge core_clk);
        ones(10, cnt);
        chk(cnt, 32'h0000_000A);
        @(posedge core_clk);
        normal_tx_bit <= 1'b0;
        repeat (3) @(posedge core_clk);
        ones(10, cnt);
        chk(cnt, 32'h0000_0000);
        @(posedge core_clk);
        normal_tx_bit <= 1'b1;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b0;
        normal_tx_bit <= 1'b0;
        repeat (2) @(posedge core_clk);
        ones(5, cnt);
        chk(cnt, 32'h0000_0005);
        @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        ones(5, cnt);
        chk(cnt, 32'h0000_0000);
        $display("test normal done");
        @(posedge core_clk);
        normal_tx_bit <= 1'b1;
        wr(8'h00, 32'h0000_8000, 1'b0);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({30'h0, line_oe, line_bit}, 32'h0000_0000);
        chk({31'h0, drv.powerdown}, 32'h0000_0001);
        $display("test powerdown done");
        conclude();
    end
endmodule
